// ==== core/reset_cause_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the reset sequencer.
`ifndef RESET_CAUSE_DEFS_SVH
`define RESET_CAUSE_DEFS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define CAUSE_OFS          8'h00
`define MASK_OFS           8'h04
`define PWR_CTL_OFS        8'h08
`define STATUS_OFS         8'h0C

// ==========================================================================
// Field positions
// ==========================================================================
`define CAUSE_W            5
`define BOR_EN_BIT         0
`define ST_SRC_LSB         0
`define ST_CORE_REL_BIT    5
`define ST_TAP_REL_BIT     6
`define ST_STATE_LSB       7
`define ST_FTP0_BIT        10
`define ST_FTP1_BIT        11

// ==========================================================================
// Reset values
// ==========================================================================
`define CAUSE_RESET        5'h00
`define MASK_RESET         5'h00
`define PWR_CTL_RESET      1'h0

// ==========================================================================
// Timing counts and bus answers
// ==========================================================================
`define SYNC_CYCLES        4
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== core/reset_cause_pkg.sv ====
// Types shared by the reset sequencer files.
package reset_cause_pkg;

   // One flag per reset source; bit 0 is the external pin.
   typedef struct packed {
      logic wdt;
      logic sw;
      logic bor;
      logic por;
      logic ext;
   } cause_t;

   // Release and boot sequence, Gray coded along the usual path.
   typedef enum logic [2:0] {
      ST_HOLD       = 3'h0,
      ST_SYNC       = 3'h1,
      ST_FETCH_SP   = 3'h3,
      ST_FETCH_PC   = 3'h2,
      ST_FETCH_INSN = 3'h6,
      ST_RUN        = 3'h7
   } boot_state_t;

   typedef enum logic [1:0] {
      KIND_SP   = 2'h0,
      KIND_PC   = 2'h1,
      KIND_INSN = 2'h2,
      KIND_NONE = 2'h3
   } fetch_kind_t;

endpackage : reset_cause_pkg

// ==== core/sync_agree.sv ====
// Three-stage input synchronizer that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module sync_agree
   import reset_cause_pkg::*;
#(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Asynchronous input and filtered output
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1 <= RESET_VAL;
         s2 <= RESET_VAL;
         s3 <= RESET_VAL;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A bit follows only where the last two stages agree, otherwise it holds.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= RESET_VAL;
      end else begin
         q <= (s2 & s3) | (q & (s2 ^ s3));
      end
   end

endmodule : sync_agree

// ==== core/reset_cause_sequencer.sv ====
// Reset source combiner, release sequencer and sticky reset cause record with AXI4-Lite access.
`timescale 1ns/1ps
`include "reset_cause_defs.svh"
module reset_cause_sequencer
   import reset_cause_pkg::*;
#(
   parameter int SYNC_CYCLES = `SYNC_CYCLES
) (
   // Clock and always-on reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   // Reset sources
   input  wire logic        EXT_RESET_N,
   input  wire logic        POR_DETECT,
   input  wire logic        BROWNOUT_DETECT,
   input  wire logic        SW_RESET_REQ,
   input  wire logic        WDT_TIMEOUT,
   input  wire logic        WDT_SERVICE,
   input  wire logic        WDT_RESET_EN,
   // Factory test pins
   input  wire logic        FACTORY_TEST_PIN_0,
   input  wire logic        FACTORY_TEST_PIN_1,
   // Reset outputs
   output logic             CORE_RESET_N,
   output logic             TAP_RESET_N,
   // Boot fetch handshake with the core
   output logic             BOOT_FETCH_REQ,
   output logic [1:0]       BOOT_FETCH_KIND,
   input  wire logic        BOOT_FETCH_DONE,
   output logic             CORE_RUN,
   // Interrupt
   output logic             IRQ,
   // AXI4-Lite write channels
   input  wire logic [7:0]  AXI_AWADDR,
   input  wire logic        AXI_AWVALID,
   output logic             AXI_AWREADY,
   input  wire logic [31:0] AXI_WDATA,
   input  wire logic [3:0]  AXI_WSTRB,
   input  wire logic        AXI_WVALID,
   output logic             AXI_WREADY,
   output logic [1:0]       AXI_BRESP,
   output logic             AXI_BVALID,
   input  wire logic        AXI_BREADY,
   // AXI4-Lite read channels
   input  wire logic [7:0]  AXI_ARADDR,
   input  wire logic        AXI_ARVALID,
   output logic             AXI_ARREADY,
   output logic [31:0]      AXI_RDATA,
   output logic [1:0]       AXI_RRESP,
   output logic             AXI_RVALID,
   input  wire logic        AXI_RREADY
);

   // =======================================================================
   // Declarations
   // =======================================================================
   logic [4:0]   pin_sync;
   logic         ext_n_s;
   logic         por_s;
   logic         bor_s;
   logic         ftp0_s;
   logic         ftp1_s;
   logic         por_done;
   logic         por_raw;
   logic         por_act;
   logic         bor_en;
   logic         wdt_first;
   logic         wdt_req;
   logic         raw_any;
   cause_t       active;
   cause_t       pending;
   cause_t       cause;
   cause_t       mask;
   cause_t       clr;
   boot_state_t  state;
   boot_state_t  next_state;
   logic [7:0]   sync_cnt;
   logic         commit;
   logic         released;
   logic         tap_rel;
   logic         aw_held;
   logic         w_held;
   logic [7:0]   awaddr_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;
   logic         do_write;
   logic         wr_ok;
   logic         wr_lane0;
   logic [31:0]  rd_word;
   logic         rd_ok;
   logic [31:0]  status_word;

   // =======================================================================
   // Source synchronization
   // =======================================================================
   // Pin synchronizer.
   sync_agree #(
      .WIDTH     (5),
      .RESET_VAL (5'h01)
   ) u_pin_sync (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d     ({FACTORY_TEST_PIN_1, FACTORY_TEST_PIN_0, BROWNOUT_DETECT, POR_DETECT,
               EXT_RESET_N}),
      .q     (pin_sync)
   );

   assign ext_n_s = pin_sync[0];
   assign por_s   = pin_sync[1];
   assign bor_s   = pin_sync[2];
   assign ftp0_s  = pin_sync[3];
   assign ftp1_s  = pin_sync[4];

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         por_done <= 1'b0;
      end else if (commit) begin
         por_done <= 1'b1;
      end
   end

   assign por_raw = POR_DETECT & ~por_done;
   assign por_act = por_s & ~por_done;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N || !released) begin
         wdt_first <= 1'b0;
      end else if (WDT_TIMEOUT) begin
         wdt_first <= 1'b1;
      end else if (WDT_SERVICE) begin
         wdt_first <= 1'b0;
      end
   end

   assign wdt_req = WDT_TIMEOUT & wdt_first & WDT_RESET_EN;

   always_comb begin
      active.ext = ~ext_n_s;
      active.por = por_act;
      active.bor = bor_s & bor_en;
      active.sw  = SW_RESET_REQ;
      active.wdt = wdt_req;
   end

   assign raw_any = ~EXT_RESET_N | por_raw | (BROWNOUT_DETECT & bor_en) | SW_RESET_REQ
                    | wdt_req;

   // =======================================================================
   // Release and boot sequence
   // =======================================================================
   always_comb begin
      next_state = state;
      case (state)
         ST_HOLD: begin
            // Wait for the later source to go inactive.
            if (active == '0) begin
               next_state = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (active != '0) begin
               next_state = ST_HOLD;
            end else if (sync_cnt == 8'(SYNC_CYCLES - 1)) begin
               next_state = ST_FETCH_SP;
            end
         end
         // Fetch order stack pointer, counter, instruction.
         ST_FETCH_SP: begin
            if (BOOT_FETCH_DONE) begin
               next_state = ST_FETCH_PC;
            end
         end
         ST_FETCH_PC: begin
            if (BOOT_FETCH_DONE) begin
               next_state = ST_FETCH_INSN;
            end
         end
         ST_FETCH_INSN: begin
            if (BOOT_FETCH_DONE) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
      // Any active source returns to hold.
      if (active != '0) begin
         next_state = ST_HOLD;
      end
   end

   assign commit = (state == ST_SYNC) && (next_state == ST_FETCH_SP);

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state <= ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N || state != ST_SYNC) begin
         sync_cnt <= 8'h00;
      end else begin
         sync_cnt <= sync_cnt + 8'h01;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         BOOT_FETCH_KIND <= KIND_NONE;
         CORE_RUN        <= 1'b0;
         released        <= 1'b0;
      end else begin
         case (next_state)
            ST_FETCH_SP:   BOOT_FETCH_KIND <= KIND_SP;
            ST_FETCH_PC:   BOOT_FETCH_KIND <= KIND_PC;
            ST_FETCH_INSN: BOOT_FETCH_KIND <= KIND_INSN;
            default:       BOOT_FETCH_KIND <= KIND_NONE;
         endcase
         CORE_RUN <= (next_state == ST_RUN);
         released <= (next_state != ST_HOLD) && (next_state != ST_SYNC);
      end
   end

   assign BOOT_FETCH_REQ = (state == ST_FETCH_SP) || (state == ST_FETCH_PC)
                           || (state == ST_FETCH_INSN);

   assign CORE_RESET_N = released & ~raw_any;

   // Test port reset from power-on only.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         tap_rel <= 1'b0;
      end else begin
         tap_rel <= ~por_act;
      end
   end

   // Pin does not reach the test port.
   assign TAP_RESET_N = tap_rel & ~por_raw;

   // =======================================================================
   // Reset cause record
   // =======================================================================
   // Separate pending flag per source.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N || commit) begin
         pending <= '0;
      end else begin
         pending <= pending | active;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         cause <= cause_t'(`CAUSE_RESET);
      end else if (commit && pending.por) begin
         cause     <= '0;
         cause.por <= 1'b1;
      end else begin
         // Sticky flags, set wins over clear.
         cause <= (cause & ~clr) | (commit ? pending : cause_t'(5'h00));
      end
   end

   assign IRQ = |(cause & mask);

   // =======================================================================
   // AXI4-Lite write path
   // =======================================================================
   assign AXI_AWREADY = ~aw_held;
   assign AXI_WREADY  = ~w_held;
   assign do_write    = aw_held & w_held & ~AXI_BVALID;
   assign wr_lane0    = do_write & wstrb_q[0];
   assign wr_ok       = (awaddr_q == `CAUSE_OFS) || (awaddr_q == `MASK_OFS)
                        || (awaddr_q == `PWR_CTL_OFS) || (awaddr_q == `STATUS_OFS);
   assign clr         = (wr_lane0 && awaddr_q == `CAUSE_OFS) ?
                        cause_t'(wdata_q[`CAUSE_W-1:0]) : cause_t'(5'h00);

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         aw_held  <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (AXI_AWVALID && !aw_held) begin
         aw_held  <= 1'b1;
         awaddr_q <= AXI_AWADDR;
      end else if (do_write) begin
         aw_held  <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         w_held  <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (AXI_WVALID && !w_held) begin
         w_held  <= 1'b1;
         wdata_q <= AXI_WDATA;
         wstrb_q <= AXI_WSTRB;
      end else if (do_write) begin
         w_held  <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         AXI_BVALID <= 1'b0;
         AXI_BRESP  <= `RESP_OKAY;
      end else if (do_write) begin
         AXI_BVALID <= 1'b1;
         AXI_BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (AXI_BREADY) begin
         AXI_BVALID <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         mask   <= cause_t'(`MASK_RESET);
         bor_en <= `PWR_CTL_RESET;
      end else if (wr_lane0) begin
         if (awaddr_q == `MASK_OFS) begin
            mask <= cause_t'(wdata_q[`CAUSE_W-1:0]);
         end else if (awaddr_q == `PWR_CTL_OFS) begin
            bor_en <= wdata_q[`BOR_EN_BIT];
         end
      end
   end

   // =======================================================================
   // AXI4-Lite read path
   // =======================================================================
   always_comb begin
      status_word = 32'h00000000;
      status_word[`ST_SRC_LSB +: `CAUSE_W] = active;
      status_word[`ST_CORE_REL_BIT]         = released;
      status_word[`ST_TAP_REL_BIT]          = tap_rel;
      status_word[`ST_STATE_LSB +: 3]       = state;
      status_word[`ST_FTP0_BIT]             = ftp0_s;
      status_word[`ST_FTP1_BIT]             = ftp1_s;
   end

   always_comb begin
      rd_word = 32'h00000000;
      rd_ok   = 1'b1;
      if (AXI_ARADDR == `CAUSE_OFS) begin
         rd_word[`CAUSE_W-1:0] = cause;
      end else if (AXI_ARADDR == `MASK_OFS) begin
         rd_word[`CAUSE_W-1:0] = mask;
      end else if (AXI_ARADDR == `PWR_CTL_OFS) begin
         rd_word[`BOR_EN_BIT] = bor_en;
      end else if (AXI_ARADDR == `STATUS_OFS) begin
         rd_word = status_word;
      end else begin
         rd_ok = 1'b0;
      end
   end

   assign AXI_ARREADY = ~AXI_RVALID;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         AXI_RVALID <= 1'b0;
         AXI_RDATA  <= 32'h00000000;
         AXI_RRESP  <= `RESP_OKAY;
      end else if (AXI_ARVALID && !AXI_RVALID) begin
         AXI_RVALID <= 1'b1;
         AXI_RDATA  <= rd_word;
         AXI_RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (AXI_RREADY) begin
         AXI_RVALID <= 1'b0;
      end
   end

endmodule : reset_cause_sequencer

// ==== sim/reset_cause_monitor.sv ====
// Concurrent checks on the reset sequencer ports.
`timescale 1ns/1ps
module reset_cause_monitor
   import reset_cause_pkg::*;
(
   // Clock and reset
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   // Sources and reset outputs
   input wire logic        EXT_RESET_N,
   input wire logic        POR_DETECT,
   input wire logic        SW_RESET_REQ,
   input wire logic        CORE_RESET_N,
   input wire logic        TAP_RESET_N,
   // Boot fetch
   input wire logic        BOOT_FETCH_REQ,
   input wire logic [1:0]  BOOT_FETCH_KIND,
   input wire logic        BOOT_FETCH_DONE,
   input wire logic        CORE_RUN,
   // Register bus
   input wire logic        AXI_AWVALID,
   input wire logic        AXI_AWREADY,
   input wire logic        AXI_WVALID,
   input wire logic        AXI_WREADY,
   input wire logic [1:0]  AXI_BRESP,
   input wire logic        AXI_BVALID,
   input wire logic        AXI_BREADY,
   input wire logic        AXI_ARVALID,
   input wire logic        AXI_ARREADY,
   input wire logic [31:0] AXI_RDATA,
   input wire logic        AXI_RVALID,
   input wire logic        AXI_RREADY
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   a_pin_holds_core: assert property (!EXT_RESET_N |-> !CORE_RESET_N)
      else $error("core reset not low with pin low");
   a_pin_spares_tap: assert property (TAP_RESET_N && !POR_DETECT |=> TAP_RESET_N)
      else $error("test port reset dropped without power-on");
   a_pin_sync_delay: assert property ($rose(EXT_RESET_N) |-> !CORE_RESET_N [*5])
      else $error("core released too soon after pin");
   a_sw_drops_core: assert property (SW_RESET_REQ |-> ##[0:1] !CORE_RESET_N)
      else $error("software request left core running");
   a_boot_starts_sp: assert property ($rose(CORE_RESET_N) |-> BOOT_FETCH_REQ
      && BOOT_FETCH_KIND == KIND_SP)
      else $error("boot does not start with stack pointer");
   a_sp_then_pc: assert property (BOOT_FETCH_REQ && BOOT_FETCH_KIND == KIND_SP
      && BOOT_FETCH_DONE |=> BOOT_FETCH_REQ && BOOT_FETCH_KIND == KIND_PC)
      else $error("program counter fetch does not follow");
   a_insn_then_run: assert property (BOOT_FETCH_REQ && BOOT_FETCH_KIND == KIND_INSN
      && BOOT_FETCH_DONE |=> CORE_RUN && !BOOT_FETCH_REQ)
      else $error("run does not follow instruction fetch");
   a_write_answer: assert property (AXI_AWVALID && AXI_AWREADY && AXI_WVALID
      && AXI_WREADY |-> ##2 AXI_BVALID)
      else $error("write response late");
   a_bresp_stands: assert property (AXI_BVALID && !AXI_BREADY |=> AXI_BVALID
      && $stable(AXI_BRESP))
      else $error("write response dropped early");
   a_read_answer: assert property (AXI_ARVALID && AXI_ARREADY |=> AXI_RVALID
      and (AXI_RVALID && !AXI_RREADY |=> $stable(AXI_RDATA)))
      else $error("read response late or unstable");
endmodule : reset_cause_monitor

// ==== sim/reset_source_model.sv ====
// Behavioural model of the reset pin and the power-on and brown-out detectors.
`timescale 1ns/1ps
module reset_source_model (
   // Clock
   input  wire logic REF_CLK,
   // Reset sources
   output logic      EXT_RESET_N,
   output logic      POR_DETECT,
   output logic      BROWNOUT_DETECT
);
   // Power-on and pin active at power-up.
   initial begin
      EXT_RESET_N = 1'b0;
      POR_DETECT = 1'b1;
      BROWNOUT_DETECT = 1'b0;
   end

   // Release detector and pin at separate times.
   task automatic power_up(input int por_cyc, input int pin_cyc);
      for (int i = 1; i <= pin_cyc; i++) begin
         @(posedge REF_CLK);
         if (i == por_cyc) POR_DETECT <= 1'b0;
         if (i == pin_cyc) EXT_RESET_N <= 1'b1;
      end
   endtask : power_up

   task automatic hold(input int which, input int n);
      for (int k = 0; k < 2; k++) begin
         @(posedge REF_CLK);
         case (which)
            0: EXT_RESET_N <= k[0];
            1: POR_DETECT <= !k[0];
            default: BROWNOUT_DETECT <= !k[0];
         endcase
         if (k == 0) repeat (n - 1) @(posedge REF_CLK);
      end
   endtask : hold
endmodule : reset_source_model

// ==== sim/reset_cause_sequencer_test.sv ====
// Self-checking bench of the reset sequencer.
`timescale 1ns/1ps
`include "reset_cause_defs.svh"
module reset_cause_sequencer_test;
   import reset_cause_pkg::*;
   logic REF_CLK, RST_N, SW_RESET_REQ, WDT_TIMEOUT, WDT_SERVICE, WDT_RESET_EN;
   logic FACTORY_TEST_PIN_0, FACTORY_TEST_PIN_1, BOOT_FETCH_DONE, IRQ, CORE_RUN;
   logic EXT_RESET_N, POR_DETECT, BROWNOUT_DETECT, CORE_RESET_N, TAP_RESET_N;
   logic BOOT_FETCH_REQ, AXI_AWVALID, AXI_AWREADY, AXI_WVALID, AXI_WREADY, AXI_BVALID;
   logic AXI_BREADY, AXI_ARVALID, AXI_ARREADY, AXI_RVALID, AXI_RREADY;
   logic [1:0]  BOOT_FETCH_KIND, AXI_BRESP, AXI_RRESP, resp;
   logic [7:0]  AXI_AWADDR, AXI_ARADDR;
   logic [3:0]  AXI_WSTRB;
   logic [31:0] AXI_WDATA, AXI_RDATA;
   logic [5:0]  klog;
   int          errors, cmp_count, cycles;

   reset_cause_sequencer dut (.*);
   reset_source_model src (.*);

   initial begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   // Core side: answer each boot fetch and log the order of kinds.
   always @(posedge REF_CLK) begin
      BOOT_FETCH_DONE <= BOOT_FETCH_REQ && !BOOT_FETCH_DONE;
      if (BOOT_FETCH_REQ && BOOT_FETCH_DONE) klog <= {klog[3:0], BOOT_FETCH_KIND};
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      int n;
      @(posedge REF_CLK);
      AXI_AWADDR <= a;
      AXI_WDATA <= d;
      AXI_AWVALID <= 1'b1;
      AXI_WVALID <= 1'b1;
      AXI_BREADY <= 1'b1;
      b = 1'b0;
      for (n = 0; !b && n < 100; n++) begin
         @(negedge REF_CLK);
         aw = AXI_AWVALID && AXI_AWREADY;
         w = AXI_WVALID && AXI_WREADY;
         b = (AXI_BVALID === 1'b1);
         resp = AXI_BRESP;
         @(posedge REF_CLK);
         if (aw) AXI_AWVALID <= 1'b0;
         if (w) AXI_WVALID <= 1'b0;
         if (b) AXI_BREADY <= 1'b0;
      end
      if (!b) errors++;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      logic ar, rv;
      int n;
      @(posedge REF_CLK);
      AXI_ARADDR <= a;
      AXI_ARVALID <= 1'b1;
      AXI_RREADY <= 1'b1;
      rv = 1'b0;
      for (n = 0; !rv && n < 100; n++) begin
         @(negedge REF_CLK);
         ar = AXI_ARVALID && AXI_ARREADY;
         rv = (AXI_RVALID === 1'b1);
         d = AXI_RDATA;
         resp = AXI_RRESP;
         @(posedge REF_CLK);
         if (ar) AXI_ARVALID <= 1'b0;
         if (rv) AXI_RREADY <= 1'b0;
      end
      if (!rv) errors++;
   endtask : axi_rd

   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      axi_rd(a, d);
      chk(name, d, e);
   endtask : rchk

   task automatic wait_run(input logic [31:0] cause);
      int n;
      for (n = 0; CORE_RUN === 1'b1 && n < 50; n++) @(negedge REF_CLK);
      for (n = 0; CORE_RUN !== 1'b1 && n < 200; n++) @(negedge REF_CLK);
      if (CORE_RUN !== 1'b1) errors++;
      chk("boot kinds", klog, 6'h06);
      rchk("cause", `CAUSE_OFS, cause);
   endtask : wait_run

   task automatic wdt(input logic t, input logic s, input logic exp_core);
      @(posedge REF_CLK);
      WDT_TIMEOUT <= t;
      WDT_SERVICE <= s;
      @(posedge REF_CLK);
      WDT_TIMEOUT <= 1'b0;
      WDT_SERVICE <= 1'b0;
      @(negedge REF_CLK);
      chk("core reset", CORE_RESET_N, exp_core);
   endtask : wdt

   initial begin
      {RST_N, SW_RESET_REQ, WDT_TIMEOUT, WDT_SERVICE, WDT_RESET_EN} = '0;
      {AXI_AWVALID, AXI_WVALID, AXI_BREADY, AXI_ARVALID, AXI_RREADY} = '0;
      {AXI_AWADDR, AXI_ARADDR, AXI_WDATA, klog, errors, cmp_count, cycles} = '0;
      {FACTORY_TEST_PIN_0, FACTORY_TEST_PIN_1, BOOT_FETCH_DONE} = 3'h4;
      AXI_WSTRB = 4'hF;
      repeat (12) @(posedge REF_CLK);
      RST_N <= 1'b1;
      @(negedge REF_CLK);
      chk("tap reset", TAP_RESET_N, 1'h0);
      src.power_up(5, 20);
      @(negedge REF_CLK);
      chk("core reset", CORE_RESET_N, 1'h0);
      wait_run(32'h02);
      chk("tap reset", TAP_RESET_N, 1'h1);
      rchk("mask", `MASK_OFS, 32'h0);
      rchk("pwr ctl", `PWR_CTL_OFS, 32'h0);
      src.hold(0, 10);
      wait_run(32'h03);
      chk("tap reset", TAP_RESET_N, 1'h1);
      axi_wr(`CAUSE_OFS, 32'h1F);
      rchk("cause", `CAUSE_OFS, 32'h0);
      src.hold(2, 10);
      @(negedge REF_CLK);
      chk("core reset", CORE_RESET_N, 1'h1);
      axi_wr(`PWR_CTL_OFS, 32'h1);
      rchk("pwr ctl", `PWR_CTL_OFS, 32'h1);
      src.hold(2, 30);
      @(negedge REF_CLK);
      chk("core reset", CORE_RESET_N, 1'h0);
      wait_run(32'h04);
      @(posedge REF_CLK);
      SW_RESET_REQ <= 1'b1;
      @(posedge REF_CLK);
      SW_RESET_REQ <= 1'b0;
      wait_run(32'h0C);
      axi_wr(`MASK_OFS, 32'h08);
      chk("irq", IRQ, 1'h1);
      axi_wr(`CAUSE_OFS, 32'h08);
      chk("irq", IRQ, 1'h0);
      rchk("cause", `CAUSE_OFS, 32'h04);
      wdt(1'b1, 1'b0, 1'b1);
      wdt(1'b1, 1'b0, 1'b1);
      wdt(1'b0, 1'b1, 1'b1);
      @(posedge REF_CLK);
      WDT_RESET_EN <= 1'b1;
      wdt(1'b1, 1'b0, 1'b1);
      wdt(1'b0, 1'b1, 1'b1);
      wdt(1'b1, 1'b0, 1'b1);
      wdt(1'b1, 1'b0, 1'b0);
      wait_run(32'h14);
      src.hold(1, 10);
      @(negedge REF_CLK);
      chk("core reset", CORE_RESET_N, 1'h1);
      chk("tap reset", TAP_RESET_N, 1'h1);
      rchk("status", `STATUS_OFS, 32'h7E0);
      rchk("unmapped", 8'h40, 32'h0);
      chk("read resp", resp, `RESP_SLVERR);
      axi_wr(8'h40, 32'h1F);
      chk("write resp", resp, `RESP_SLVERR);
      tally_and_finish();
   end
endmodule : reset_cause_sequencer_test

bind reset_cause_sequencer reset_cause_monitor mon (.*);
